//--- nrp_consts.svh
// offsets, field positions, masks, unlock keys and response codes of the nmi reset/power block
`ifndef NRP_CONSTS_SVH
`define NRP_CONSTS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define NRP_OFF_SOFTWARE_RESET_TRIGGER     4'h0
`define NRP_OFF_NMI       4'h4
`define NRP_OFF_PWR       4'h8
`define NRP_OFF_UNLOCK    4'hc
// ----------------------------------------
// field positions
// ----------------------------------------
`define NRP_BIT_WDT_RUN   24
`define NRP_BIT_SW_NMI    23
`define NRP_BIT_GEN_NMI   19
`define NRP_BIT_CLK_FAIL  17
`define NRP_BIT_WDT_SLEEP 16
`define NRP_BIT_SLP_BOR   2
`define NRP_BIT_REGULATOR_RETENTION_SELECT     1
`define NRP_BIT_VREG_ACT  0
`define NRP_BIT_SOFTWARE_RESET_TRIGGER     0
// ----------------------------------------
// values
// ----------------------------------------
`define NRP_NMI_MASK      32'h018bffff
`define NRP_PWR_MASK      32'h00000007
`define NRP_UNLOCK_KEY1   32'haa996655
`define NRP_UNLOCK_KEY2   32'h556699aa
`define NRP_BOR_SLEEP_CFG 2'h1
`define NRP_RESP_OKAY     2'h0
`define NRP_RESP_SLVERR   2'h2
`endif

//--- nrp_pkg.sv
// types of the nmi reset/power block
package nrp_pkg;
	typedef enum logic [1:0] {
		NRP_LK_LOCKED = 2'b00,
		NRP_LK_KEY1   = 2'b01,
		NRP_LK_OPEN   = 2'b10
	} nrp_lock_t;
endpackage : nrp_pkg

//--- nrp_nmi_reset_power.sv
// nmi cause latching, nmi reset counter, sleep power bits and software reset
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "nrp_consts.svh"
module nrp_nmi_reset_power
	import nrp_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic        sys_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        wdt_run_timeout_i,
	input  wire logic        wdt_sleep_timeout_i,
	input  wire logic        clk_fail_detect_i,
	input  wire logic [1:0]  brownout_config_field_i,
	output logic             nmi_o,
	output logic             wdt_nmi_o,
	output logic             clk_fail_switch_o,
	output logic             device_reset_o,
	output logic             sleep_brownout_on_o,
	output logic             regulator_low_power_o,
	output logic             regulator_sleep_active_o,
	output logic             locked_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	nrp_lock_t          lock_state;
	logic               wdt_run_flag;
	logic               sw_nmi_flag;
	logic               gen_nmi_flag;
	logic               clk_fail_flag;
	logic               wdt_sleep_flag;
	logic [CNT_W-1:0]   reload_value;
	logic [CNT_W-1:0]   count;
	logic               counting;
	logic               software_reset_trigger_armed;
	logic [2:0]         pwr_bits;
	logic               aw_held;
	logic               w_held;
	logic [3:0]         aw_addr;
	logic [31:0]        w_data;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// write address and data are taken independently, response after both
	wire        wr_go      = aw_held && w_held && !s_axi_bvalid;
	wire        full_word  = (s_axi_wstrb == 4'hf);
	wire        wr_nmi     = wr_go && aw_addr == `NRP_OFF_NMI;
	wire        wr_pwr     = wr_go && aw_addr == `NRP_OFF_PWR;
	wire        wr_software_reset_trigger   = wr_go && aw_addr == `NRP_OFF_SOFTWARE_RESET_TRIGGER;
	wire        wr_unlock  = wr_go && aw_addr == `NRP_OFF_UNLOCK;
	wire        unlocked   = (lock_state == NRP_LK_OPEN);
	wire        nmi_we     = wr_nmi && unlocked;
	wire        pwr_we     = wr_pwr && unlocked;
	wire        wr_mapped  = wr_nmi || wr_pwr || wr_software_reset_trigger || wr_unlock;
	wire        rd_go      = s_axi_arvalid && !s_axi_rvalid;
	wire        rd_software_reset_trigger   = rd_go && s_axi_araddr == `NRP_OFF_SOFTWARE_RESET_TRIGGER;
	wire        rd_mapped  = rd_software_reset_trigger || s_axi_araddr == `NRP_OFF_NMI
	                      || s_axi_araddr == `NRP_OFF_PWR || s_axi_araddr == `NRP_OFF_UNLOCK;
	// software set of the run watchdog bit (a one written there raises a run event)
	wire        sw_set_run   = nmi_we && w_data[`NRP_BIT_WDT_RUN];
	wire        run_event    = wdt_run_timeout_i || sw_set_run;
	wire [31:0] nmi_rd = {7'h0, wdt_run_flag, sw_nmi_flag, 3'h0, gen_nmi_flag, 1'b0,
	                      clk_fail_flag, wdt_sleep_flag, reload_value};

	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign s_axi_arready = !s_axi_rvalid;

	// ----------------------------------------
	// write channel capture and response
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 4'h0;
			w_data       <= 32'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `NRP_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= full_word ? s_axi_wdata : 32'h0; // partial writes store zero data
			end
			if (wr_go) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? `NRP_RESP_OKAY : `NRP_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	// software reset register is write-only and reads zero
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `NRP_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= rd_mapped ? `NRP_RESP_OKAY : `NRP_RESP_SLVERR;
			case (s_axi_araddr)
				`NRP_OFF_NMI:    s_axi_rdata <= nmi_rd;
				`NRP_OFF_PWR:    s_axi_rdata <= {29'h0, pwr_bits};
				`NRP_OFF_UNLOCK: s_axi_rdata <= {31'h0, unlocked};
				default:         s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// unlock sequence
	// ----------------------------------------
	// two key words in a row open the gate; any other write to the key relocks
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lock_state <= NRP_LK_LOCKED;
		end else if (wr_unlock) begin
			case (lock_state)
				NRP_LK_LOCKED: lock_state <= (w_data == `NRP_UNLOCK_KEY1) ? NRP_LK_KEY1
				                            : NRP_LK_LOCKED;
				NRP_LK_KEY1:   lock_state <= (w_data == `NRP_UNLOCK_KEY2) ? NRP_LK_OPEN
				                            : NRP_LK_LOCKED;
				default:       lock_state <= NRP_LK_LOCKED;
			endcase
		end
	end
	assign locked_o = !unlocked;

	// ----------------------------------------
	// nmi cause flags
	// ----------------------------------------
	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wdt_run_flag   <= 1'b0;
			sw_nmi_flag    <= 1'b0;
			gen_nmi_flag   <= 1'b0;
			clk_fail_flag  <= 1'b0;
			wdt_sleep_flag <= 1'b0;
			reload_value   <= '0;
		end else begin
			if (nmi_we) begin
				wdt_run_flag   <= w_data[`NRP_BIT_WDT_RUN];
				sw_nmi_flag    <= w_data[`NRP_BIT_SW_NMI];
				gen_nmi_flag   <= w_data[`NRP_BIT_GEN_NMI];
				clk_fail_flag  <= w_data[`NRP_BIT_CLK_FAIL];
				wdt_sleep_flag <= w_data[`NRP_BIT_WDT_SLEEP];
				reload_value   <= w_data[CNT_W-1:0];
			end
			if (wdt_run_timeout_i)
				wdt_run_flag <= 1'b1;
			if (clk_fail_detect_i)
				clk_fail_flag <= 1'b1;
			if (wdt_sleep_timeout_i)
				wdt_sleep_flag <= 1'b1;
		end
	end

	// nmi request stays high while any cause is recorded
	assign nmi_o     = wdt_run_flag | sw_nmi_flag | gen_nmi_flag | clk_fail_flag
	                 | wdt_sleep_flag;
	assign wdt_nmi_o = wdt_run_flag | wdt_sleep_flag;
	// only the monitor's own detection switches oscillator; a software set has no path here,
	// and a real failure is never masked by a register write in the same cycle
	assign clk_fail_switch_o = clk_fail_detect_i;

	// ----------------------------------------
	// nmi reset counter and reset output
	// ----------------------------------------
	// only run-mode watchdog events start it; a cleared flag aborts it
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count          <= '0;
			counting       <= 1'b0;
			software_reset_trigger_armed    <= 1'b0;
			device_reset_o <= 1'b0;
		end else begin
			device_reset_o <= 1'b0;
			if (run_event && !counting) begin
				count    <= reload_value;
				// a zero reload resets at once and leaves nothing to count, so no second pulse
				counting <= (reload_value != '0);
				if (reload_value == '0)
					device_reset_o <= 1'b1;
			end else if (counting && !wdt_run_flag) begin
				counting <= 1'b0;
			end else if (counting) begin
				count <= count - 1'b1;
				// firing on the last step puts reset exactly reload cycles after the flag
				if (count == CNT_W'(1)) begin
					device_reset_o <= 1'b1;
					counting       <= 1'b0;
				end
			end
			if (wr_software_reset_trigger && unlocked && w_data[`NRP_BIT_SOFTWARE_RESET_TRIGGER])
				software_reset_trigger_armed <= 1'b1;
			if (rd_software_reset_trigger && software_reset_trigger_armed) begin
				device_reset_o <= 1'b1;
				software_reset_trigger_armed    <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// power control
	// ----------------------------------------
	// retention select is set-only: a zero write leaves it alone
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pwr_bits <= 3'h0;
		end else if (pwr_we) begin
			pwr_bits[`NRP_BIT_SLP_BOR]  <= w_data[`NRP_BIT_SLP_BOR];
			pwr_bits[`NRP_BIT_VREG_ACT] <= w_data[`NRP_BIT_VREG_ACT];
			if (w_data[`NRP_BIT_REGULATOR_RETENTION_SELECT])
				pwr_bits[`NRP_BIT_REGULATOR_RETENTION_SELECT] <= 1'b1;
		end
	end
	// when the config field is not 01 the bit has no say: detector left off in sleep
	assign sleep_brownout_on_o = pwr_bits[`NRP_BIT_SLP_BOR]
	                          && brownout_config_field_i == `NRP_BOR_SLEEP_CFG;
	assign regulator_low_power_o    = pwr_bits[`NRP_BIT_REGULATOR_RETENTION_SELECT];
	assign regulator_sleep_active_o = pwr_bits[`NRP_BIT_VREG_ACT];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_RUN_FLAG_SET: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		wdt_run_timeout_i |=> wdt_run_flag)
		else $error("run watchdog flag not set by timeout");
	AST_SLEEP_FLAG_SET: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		wdt_sleep_timeout_i |=> wdt_sleep_flag && wdt_nmi_o)
		else $error("sleep watchdog flag or nmi missing");
	AST_SOFTWARE_RESET_TRIGGER_READ: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		rd_software_reset_trigger && software_reset_trigger_armed |=> device_reset_o && !software_reset_trigger_armed)
		else $error("armed software reset read gave no reset");
	AST_ZERO_RELOAD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		run_event && !counting && reload_value == '0 |=> device_reset_o)
		else $error("zero reload did not reset at once");
	AST_COUNT_DOWN: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		counting && wdt_run_flag && count != '0 && !run_event |=> count == $past(count) - 1'b1)
		else $error("nmi reset counter did not decrement");
	AST_NO_RESET_CLEARED: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		counting && !wdt_run_flag && !rd_software_reset_trigger |=> !device_reset_o && !counting)
		else $error("reset after watchdog nmi cleared");
	AST_LOCKED_WRITE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		wr_pwr && !unlocked |=> $stable(pwr_bits))
		else $error("locked power write took effect");
	AST_NMI_LEVEL: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		nmi_we && w_data[`NRP_BIT_SW_NMI] |=> nmi_o && sw_nmi_flag)
		else $error("software nmi not raised");
	AST_BOR_GATE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		brownout_config_field_i != `NRP_BOR_SLEEP_CFG |-> !sleep_brownout_on_o)
		else $error("sleep brown-out acted with wrong config");
	AST_REGULATOR_RETENTION_SELECT_STICKY: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		regulator_low_power_o |=> regulator_low_power_o)
		else $error("retention select cleared by write");
	AST_RESERVED_ZERO: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		s_axi_rvalid && !$past(s_axi_rvalid) |-> (s_axi_rdata & ~`NRP_NMI_MASK) == 32'h0)
		else $error("reserved bits read nonzero");
	AST_COUNT_END: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		counting && wdt_run_flag && count == CNT_W'(1) |=> device_reset_o && !counting)
		else $error("counted reset not on time");
endmodule : nrp_nmi_reset_power

//--- nrp_event_model.sv
// event source model: run watchdog, sleep watchdog and clock monitor
`timescale 1ns/1ps
module nrp_event_model (
	input  wire logic       sys_clk_i,
	input  wire logic       fire_i,
	input  wire logic [1:0] sel_i,
	output logic            wdt_run_o,
	output logic            wdt_sleep_o,
	output logic            clk_fail_o
);
	// ----------------------------------------
	// event pulses
	// ----------------------------------------
	// one-cycle pulses, so a test never leans on a cause that stays high
	logic [2:0] pulse = 3'h0; // quiet until the first edge
	always @(posedge sys_clk_i) begin
		pulse <= {fire_i && sel_i == 2'h2, fire_i && sel_i == 2'h1, fire_i && sel_i == 2'h0};
	end
	assign wdt_run_o   = pulse[0];
	assign wdt_sleep_o = pulse[1];
	assign clk_fail_o  = pulse[2];
endmodule : nrp_event_model

//--- nrp_nmi_reset_power_tb.sv
// self-checking testbench of the nmi reset/power block
`timescale 1ns/1ps
`include "nrp_consts.svh"
module nrp_nmi_reset_power_tb;
	import nrp_pkg::*;
	logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, fire = 0;
	logic [3:0]  awa = 0, ara = 0;
	logic [31:0] wd = 0, rdat;
	logic [1:0]  sel = 0, cfg = 0, resp;
	logic        awr, wr, bv, arr, rv, wrun, wslp, cf, nmi, wnmi, cfsw, drst, sbor, rlp, rsa, lck;
	logic [1:0]  br, rr;
	logic [31:0] rd;
	logic        rst_seen = 0;
	int          cyc = 0, rst_cyc, fails = 0, tests_run = 0, d2, d6;
	always #5 clk = ~clk;
	always @(posedge clk) cyc++;
	// latch the first reset pulse, it stands for a single cycle only
	always @(negedge clk) if (drst === 1'b1 && !rst_seen) begin
		rst_seen = 1;
		rst_cyc = cyc;
	end
	nrp_nmi_reset_power uut (.sys_clk_i(clk), .reset_n_i(rst_n), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.wdt_run_timeout_i(wrun), .wdt_sleep_timeout_i(wslp), .clk_fail_detect_i(cf),
		.brownout_config_field_i(cfg), .nmi_o(nmi), .wdt_nmi_o(wnmi), .clk_fail_switch_o(cfsw),
		.device_reset_o(drst), .sleep_brownout_on_o(sbor), .regulator_low_power_o(rlp),
		.regulator_sleep_active_o(rsa), .locked_o(lck));
	nrp_event_model src (.sys_clk_i(clk), .fire_i(fire), .sel_i(sel), .wdt_run_o(wrun),
		.wdt_sleep_o(wslp), .clk_fail_o(cf));
	// ----------------------------------------
	// common tasks
	// ----------------------------------------
	task automatic report_and_stop;
		$display("tests_run %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// ready is sampled at the falling edge, where it is settled, and the release
	// lands right after the rising edge that took the item
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		int n;
		@(posedge clk);
		{awa, wd} <= {a, d};
		{awv, wv, bry} <= 3'h7;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			{ta, tw, tb} = {awv & awr, wv & wr, bv};
			resp = br;
			@(posedge clk);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
			if (tb) break;
		end
		bry <= 0;
		if (n == 50) begin
			fails++;
			report_and_stop();
		end
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a);
		logic ta, tr;
		int n;
		@(posedge clk);
		ara <= a;
		{arv, rry} <= 2'h3;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			{ta, tr} = {arv & arr, rv};
			{rdat, resp} = {rd, rr};
			@(posedge clk);
			if (ta) arv <= 0;
			if (tr) break;
		end
		rry <= 0;
		if (n == 50) begin
			fails++;
			report_and_stop();
		end
	endtask : rd_reg
	task automatic do_reset;
		@(posedge clk);
		rst_n <= 0;
		tick(5);
		rst_n <= 1;
		rst_seen = 0;
	endtask : do_reset
	// a leading non-key write relocks first, so the keys start clean from either state
	task automatic unlock;
		wr_reg(`NRP_OFF_UNLOCK, 32'h0);
		wr_reg(`NRP_OFF_UNLOCK, `NRP_UNLOCK_KEY1);
		wr_reg(`NRP_OFF_UNLOCK, `NRP_UNLOCK_KEY2);
	endtask : unlock
	// pulse one event source and stop where the pulse is visible
	task automatic fire_ev(input logic [1:0] s);
		@(posedge clk);
		{fire, sel} <= {1'b1, s};
		@(posedge clk);
		fire <= 0;
		@(negedge clk);
	endtask : fire_ev
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_lock_power;
		rd_reg(4'h2);
		check("unmapped rd", {resp, rdat}, {`NRP_RESP_SLVERR, 32'h0});
		wr_reg(4'h2, 32'h1);
		check("unmapped wr", resp, `NRP_RESP_SLVERR);
		check("locked", lck, 1);
		wr_reg(`NRP_OFF_PWR, 32'h7);
		check("locked resp", resp, `NRP_RESP_OKAY);
		rd_reg(`NRP_OFF_PWR);
		check("pwr locked", rdat, 0);
		unlock();
		cfg <= `NRP_BOR_SLEEP_CFG;
		wr_reg(`NRP_OFF_PWR, 32'hffffffff);
		rd_reg(`NRP_OFF_PWR);
		check("pwr ones", rdat, 32'h7);
		check("sbor on", {sbor, rlp, rsa}, 3'h7);
		cfg <= 2'h2;
		@(negedge clk);
		check("sbor gated", sbor, 0);
		wr_reg(`NRP_OFF_PWR, 32'h0);
		rd_reg(`NRP_OFF_PWR);
		check("pwr zero", rdat, 32'h2);
		check("sbor cfg", {sbor, rlp, rsa}, 3'h2);
	endtask : s_lock_power
	task automatic s_nmi_causes;
		unlock();
		wr_reg(`NRP_OFF_NMI, 32'hfe740003);
		rd_reg(`NRP_OFF_NMI);
		check("nmi unimpl", {nmi, rdat}, 33'h3);
		wr_reg(`NRP_OFF_NMI, 32'h00880003);
		rd_reg(`NRP_OFF_NMI);
		check("sw gen nmi", {nmi, wnmi, rdat}, 34'h200880003);
		fire_ev(2'h2);
		check("clk switch", cfsw, 1);
		tick(20);
		check("no count", rst_seen, 0);
		fire_ev(2'h1);
		tick(2);
		rd_reg(`NRP_OFF_NMI);
		check("hw flags", {wnmi, rdat}, 33'h1008b0003);
		do_reset();
		unlock();
		wr_reg(`NRP_OFF_NMI, 32'h00020000);
		check("sw clk fail", {nmi, cfsw}, 2'h2);
		wr_reg(`NRP_OFF_NMI, 32'h00010000);
		check("sw sleep", wnmi, 1);
		do_reset();
	endtask : s_nmi_causes
	task automatic delay(input logic [15:0] n, output int d);
		int t0, k;
		unlock();
		wr_reg(`NRP_OFF_NMI, {16'h0, n});
		rst_seen = 0;
		fire_ev(2'h0);
		t0 = cyc;
		for (k = 0; k < 100 && !rst_seen; k++) @(negedge clk);
		if (!rst_seen) begin
			fails++;
			report_and_stop();
		end
		d = rst_cyc - t0;
		do_reset();
	endtask : delay
	task automatic s_counter;
		delay(16'h2, d2);
		delay(16'h6, d6);
		check("count span", d6 - d2, 4);
		// flag seen one cycle after the pulse, reset two reload cycles after the flag
		check("count abs", d2, 3);
		unlock();
		wr_reg(`NRP_OFF_NMI, 32'h01000000);
		tick(3);
		check("zero reload", rst_seen, 1);
		do_reset();
		unlock();
		wr_reg(`NRP_OFF_NMI, 32'h28);
		fire_ev(2'h0);
		rd_reg(`NRP_OFF_NMI);
		check("run flag", {wnmi, rdat}, 33'h101000028);
		wr_reg(`NRP_OFF_NMI, 32'h28);
		tick(60);
		check("aborted", rst_seen, 0);
		wr_reg(`NRP_OFF_UNLOCK, 32'h0);
		wr_reg(`NRP_OFF_NMI, 32'h00800000);
		rd_reg(`NRP_OFF_NMI);
		check("relocked", {lck, rdat}, 33'h100000028);
	endtask : s_counter
	task automatic s_soft_reset;
		do_reset();
		wr_reg(`NRP_OFF_SOFTWARE_RESET_TRIGGER, 32'h1);
		rd_reg(`NRP_OFF_SOFTWARE_RESET_TRIGGER);
		tick(3);
		check("software_reset_trigger locked", {rst_seen, rdat}, 0);
		unlock();
		wr_reg(`NRP_OFF_SOFTWARE_RESET_TRIGGER, 32'h0);
		rd_reg(`NRP_OFF_SOFTWARE_RESET_TRIGGER);
		tick(3);
		check("software_reset_trigger zero", rst_seen, 0);
		wr_reg(`NRP_OFF_SOFTWARE_RESET_TRIGGER, 32'h1);
		rd_reg(`NRP_OFF_SOFTWARE_RESET_TRIGGER);
		tick(3);
		check("software_reset_trigger read", rst_seen, 1);
	endtask : s_soft_reset
	initial begin
		tick(5);
		rst_n <= 1;
		s_lock_power();
		s_nmi_causes();
		s_counter();
		s_soft_reset();
		report_and_stop();
	end
endmodule : nrp_nmi_reset_power_tb
